//--- hdl/telemetry_fec_decode_select.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Function
// R1: two ldpc block sizes, 4096 and 1024
// R2: three ldpc rates, 1/2 2/3 4/5
// R3: ldpc only in the two ldpc modes
// R4: decode with configured size and rate pair
// R5: derandomizer none/range/space, ldpc modes only
// R6: transmitter randomization must match derandomizer
// R7: afc off recommended with ldpc
// R8: ldpc code setting visible only in ldpc modes
// R9: viterbi is k7 rate one half
// R10: viterbi needs option and legacy psk mode
// R11: viterbi and rs enable independently
// R12: symbol off: separate i and q decoders; in bpsk mode only the i decoder is enabled
// R13: symbol on: i=g1, q=g2, joint decoder
// R14: rs works on 8-bit symbols
// R15: rs code is (255,223)
// R16: rs needs option and legacy psk mode
// R17: single rs; asymmetric b stream bypasses
// R18: rs is outer code after viterbi
// R19: deinterleave n blocks per depth setting
// R20: depth accepts one through eight
// R21: bad depth rejected, old value kept
// R22: unavailable decoder is bypassed
module telemetry_fec_decode_select (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // option strap
    input  wire logic        convolutional_decoding_option,
    // routing and configuration to the decoder cores
    output logic             ldpc_en,
    output logic [12:0]      ldpc_k,
    output logic [1:0]       ldpc_rate,
    output logic [1:0]       derand_sel,
    output logic             ldpc_menu_visible,
    output logic             vit_i_en,
    output logic             vit_q_en,
    output logic             vit_joint,
    output logic             rs_en,
    output logic             rs_b_bypass,
    output logic [3:0]       rs_depth,
    output logic             legacy_menu_visible,
    output logic             path_bypass
);

    // strap is static but off-chip, so it is synchronised
    logic        opt_meta_ff;
    logic        opt_sync_ff;

    logic [3:0]  mode_ff;
    logic        ldpc_size_ff;
    logic [1:0]  ldpc_rate_ff;
    logic [1:0]  ldpc_drnd_ff;
    logic        vit_en_ff;
    logic        rs_en_ff;
    logic        csym_ff;
    logic [3:0]  depth_ff;
    logic        depth_err_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    logic        ldpc_en_ff;
    logic [12:0] ldpc_k_ff;
    logic [1:0]  ldpc_rate_o_ff;
    logic [1:0]  derand_ff;
    logic        vit_i_ff;
    logic        vit_q_ff;
    logic        vit_joint_ff;
    logic        rs_en_o_ff;
    logic        rs_b_ff;
    logic [3:0]  rs_depth_ff;
    logic        legacy_vis_ff;
    logic        bypass_ff;

    function automatic logic is_legacy(input logic [3:0] m);
        is_legacy = (m == fec_select_pkg::MODE_BPSK)  || (m == fec_select_pkg::MODE_QPSK)  ||
                    (m == fec_select_pkg::MODE_OQPSK) || (m == fec_select_pkg::MODE_UQPSK) ||
                    (m == fec_select_pkg::MODE_ASYMMETRIC_QUADRATURE_PSK) || (m == fec_select_pkg::MODE_ASYMMETRIC_UNBALANCED_QUADRATURE_PSK);
    endfunction

    function automatic logic is_ldpc(input logic [3:0] m);
        is_ldpc = (m == fec_select_pkg::MODE_SOQ_LDPC) || (m == fec_select_pkg::MODE_STC_LDPC);
    endfunction

    // decode
    wire         acc         = psel && penable;
    wire         wr          = acc && pwrite;
    wire         hit_mode    = (paddr == fec_select_pkg::ADDR_MODE);
    wire         hit_ldpc    = (paddr == fec_select_pkg::ADDR_LDPC);
    wire         hit_legacy  = (paddr == fec_select_pkg::ADDR_LEGACY);
    wire         hit_depth   = (paddr == fec_select_pkg::ADDR_DEPTH);
    wire         hit_status  = (paddr == fec_select_pkg::ADDR_STATUS);
    wire         hit_any     = hit_mode || hit_ldpc || hit_legacy || hit_depth || hit_status;
    wire [3:0]   wr_depth    = pwdata[3:0];
    wire         depth_ok    = (pwdata[31:4] == 28'h0000000) &&
                               (wr_depth >= fec_select_pkg::DEPTH_MIN) &&
                               (wr_depth <= fec_select_pkg::DEPTH_MAX); // R20
    wire [1:0]   wr_rate     = pwdata[fec_select_pkg::LDPC_RATE_LSB +: 2];
    wire [1:0]   wr_drnd     = pwdata[fec_select_pkg::LDPC_DRND_LSB +: 2];
    // code 3 is not a rate or derandomizer; keep old value
    wire         rate_ok     = (wr_rate != 2'h3); // R2
    wire         drnd_ok     = (wr_drnd != 2'h3); // R5

    // mode qualification
    wire         ldpc_mode   = is_ldpc(mode_ff); // R3
    wire         legacy_ok   = opt_sync_ff && is_legacy(mode_ff); // R10 R16
    wire         asym_mode   = (mode_ff == fec_select_pkg::MODE_ASYMMETRIC_QUADRATURE_PSK) ||
                               (mode_ff == fec_select_pkg::MODE_ASYMMETRIC_UNBALANCED_QUADRATURE_PSK);
    wire         vit_act     = legacy_ok && vit_en_ff; // R11 R22
    wire         rs_act      = legacy_ok && rs_en_ff; // R11 R22
    wire         bpsk_mode   = (mode_ff == fec_select_pkg::MODE_BPSK);

    wire         nxt_ldpc_en = ldpc_mode; // R3 R22
    wire [12:0]  nxt_k       = ldpc_size_ff ? fec_select_pkg::K_SMALL
                                            : fec_select_pkg::K_LARGE; // R1 R4
    wire [1:0]   nxt_drnd    = ldpc_mode ? ldpc_drnd_ff : fec_select_pkg::DRND_NONE; // R5
    wire         nxt_joint   = vit_act && csym_ff; // R13
    wire         nxt_vit_i   = vit_act; // R9 R12
    // bpsk has no q stream to decode separately
    wire         nxt_vit_q   = vit_act && !csym_ff && !bpsk_mode; // R12
    wire         nxt_rs_b    = rs_act && asym_mode; // R17
    wire         nxt_bypass  = !ldpc_mode && !vit_act && !rs_act; // R22

    wire [31:0]  status_word = {25'h0000000, depth_err_ff, nxt_bypass, nxt_vit_q,
                                nxt_joint, rs_act, vit_act, ldpc_mode};
    wire [31:0]  nxt_prdata  = hit_mode   ? {28'h0000000, mode_ff} :
                               hit_ldpc   ? {26'h0000000, ldpc_drnd_ff, 1'b0, ldpc_size_ff,
                                             ldpc_rate_ff} :
                               hit_legacy ? {29'h00000000, csym_ff, rs_en_ff, vit_en_ff} :
                               hit_depth  ? {28'h0000000, depth_ff} :
                               hit_status ? status_word : 32'h00000000;

    always_ff @(posedge sys_clk) begin
        opt_meta_ff <= sys_rst ? 1'b0 : convolutional_decoding_option;
        opt_sync_ff <= sys_rst ? 1'b0 : opt_meta_ff;
    end

    // zero-wait apb: pready follows the setup cycle by one edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= psel && !penable && !hit_any;
            prdata_ff  <= (psel && !penable && !pwrite) ? nxt_prdata : 32'h00000000;
        end
    end

    // stored enables survive a mode change; only the outputs are gated
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_ff <= fec_select_pkg::MODE_PCMFM;
        end else if (wr && hit_mode) begin
            mode_ff <= pwdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ldpc_size_ff <= 1'b0;
            ldpc_rate_ff <= fec_select_pkg::RATE_1_2;
            ldpc_drnd_ff <= fec_select_pkg::DRND_NONE;
        end else if (wr && hit_ldpc) begin
            ldpc_size_ff <= pwdata[fec_select_pkg::LDPC_SIZE_BIT]; // R1
            ldpc_rate_ff <= rate_ok ? wr_rate : ldpc_rate_ff; // R2
            ldpc_drnd_ff <= drnd_ok ? wr_drnd : ldpc_drnd_ff; // R5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vit_en_ff <= 1'b0;
            rs_en_ff  <= 1'b0;
            csym_ff   <= 1'b0;
        end else if (wr && hit_legacy) begin
            vit_en_ff <= pwdata[fec_select_pkg::VIT_EN_BIT]; // R11
            rs_en_ff  <= pwdata[fec_select_pkg::RS_EN_BIT]; // R11
            csym_ff   <= pwdata[fec_select_pkg::CSYM_BIT]; // R12 R13
        end
    end

    // the error flag clears on the next accepted depth
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            depth_ff     <= fec_select_pkg::DEPTH_MIN;
            depth_err_ff <= 1'b0;
        end else if (wr && hit_depth) begin
            depth_ff     <= depth_ok ? wr_depth : depth_ff; // R21
            depth_err_ff <= !depth_ok; // R21
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ldpc_en_ff     <= 1'b0;
            ldpc_k_ff      <= fec_select_pkg::K_LARGE;
            ldpc_rate_o_ff <= fec_select_pkg::RATE_1_2;
            derand_ff      <= fec_select_pkg::DRND_NONE;
        end else begin
            ldpc_en_ff     <= nxt_ldpc_en; // R3 R8
            ldpc_k_ff      <= nxt_k; // R4
            ldpc_rate_o_ff <= ldpc_rate_ff; // R4
            derand_ff      <= nxt_drnd; // R5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vit_i_ff     <= 1'b0;
            vit_q_ff     <= 1'b0;
            vit_joint_ff <= 1'b0;
        end else begin
            vit_i_ff     <= nxt_vit_i; // R12 R13
            vit_q_ff     <= nxt_vit_q; // R12
            vit_joint_ff <= nxt_joint; // R13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rs_en_o_ff    <= 1'b0;
            rs_b_ff       <= 1'b0;
            rs_depth_ff   <= fec_select_pkg::DEPTH_MIN;
            legacy_vis_ff <= 1'b0;
            bypass_ff     <= 1'b1;
        end else begin
            rs_en_o_ff    <= rs_act; // R14 R15 R18
            rs_b_ff       <= nxt_rs_b; // R17
            rs_depth_ff   <= depth_ff; // R19
            legacy_vis_ff <= legacy_ok; // R10 R16
            bypass_ff     <= nxt_bypass; // R22
        end
    end

    assign prdata              = prdata_ff;
    assign pready              = pready_ff;
    assign pslverr             = pslverr_ff;
    assign ldpc_en             = ldpc_en_ff;
    assign ldpc_k              = ldpc_k_ff;
    assign ldpc_rate           = ldpc_rate_o_ff;
    assign derand_sel          = derand_ff;
    assign ldpc_menu_visible   = ldpc_en_ff; // R8
    assign vit_i_en            = vit_i_ff;
    assign vit_q_en            = vit_q_ff;
    assign vit_joint           = vit_joint_ff;
    assign rs_en               = rs_en_o_ff;
    assign rs_b_bypass         = rs_b_ff;
    assign rs_depth            = rs_depth_ff;
    assign legacy_menu_visible = legacy_vis_ff;
    assign path_bypass         = bypass_ff;

    // checks
    AST_LDPC_MODE: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
        ldpc_en |-> is_ldpc($past(mode_ff)))
        else $error("ldpc enabled outside ldpc mode");
    AST_LDPC_VIS: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
        ldpc_menu_visible == ldpc_en)
        else $error("ldpc menu visibility wrong");
    AST_K_SIZE: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
        (ldpc_k == fec_select_pkg::K_LARGE) || (ldpc_k == fec_select_pkg::K_SMALL))
        else $error("bad ldpc block size");
    AST_RATE_OK: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
        ldpc_rate != 2'h3)
        else $error("bad ldpc rate");
    AST_DRND_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
        !ldpc_en |-> derand_sel == fec_select_pkg::DRND_NONE)
        else $error("derandomizer active outside ldpc");
    AST_VIT_AVAIL: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
        vit_i_en |-> legacy_menu_visible)
        else $error("viterbi on without option or legacy mode");
    AST_RS_AVAIL: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
        rs_en |-> legacy_menu_visible)
        else $error("rs on without option or legacy mode");
    AST_JOINT_EXCL: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
        vit_joint |-> vit_i_en && !vit_q_en)
        else $error("joint decode with separate q decoder");
    AST_RS_B: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
        rs_b_bypass |-> rs_en)
        else $error("b bypass without rs");
    AST_DEPTH_RANGE: assert property (@(posedge sys_clk) disable iff (sys_rst) // R20
        (rs_depth >= fec_select_pkg::DEPTH_MIN) && (rs_depth <= fec_select_pkg::DEPTH_MAX))
        else $error("depth out of range");
    AST_DEPTH_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst) // R21
        (wr && hit_depth && !depth_ok) |=> depth_ff == $past(depth_ff))
        else $error("bad depth not rejected");
    AST_BYPASS: assert property (@(posedge sys_clk) disable iff (sys_rst) // R22
        path_bypass |-> !ldpc_en && !vit_i_en && !rs_en)
        else $error("bypass with decoder on");

    // follow-through: each output trails its stored setting by one edge
    AST_RATE_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
        ldpc_rate == $past(ldpc_rate_ff))
        else $error("ldpc rate not applied");

    AST_K_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1 R4
        (ldpc_k == fec_select_pkg::K_SMALL) == $past(ldpc_size_ff))
        else $error("ldpc block size not applied");

    AST_DRND_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
        ldpc_en |-> derand_sel == $past(ldpc_drnd_ff))
        else $error("derandomizer not applied");

    AST_LDPC_ALONE: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
        ldpc_en |-> !legacy_menu_visible && !vit_i_en && !rs_en)
        else $error("ldpc together with legacy decoding");

    AST_VIT_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11 R22
        vit_i_en == $past(vit_act))
        else $error("viterbi enable not applied");

    AST_RS_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11 R22
        rs_en == $past(rs_act))
        else $error("rs enable not applied");

    AST_JOINT_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
        vit_joint == $past(vit_act && csym_ff))
        else $error("joint decode setting not applied");

    AST_SEP_Q: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
        vit_q_en |-> vit_i_en && !vit_joint)
        else $error("q decoder without separate i decoder");

    AST_VIS_OPT: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10 R16
        legacy_menu_visible |-> $past(opt_sync_ff))
        else $error("legacy controls shown without option");

    AST_RS_B_ASYM: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
        rs_b_bypass == $past(rs_act && asym_mode))
        else $error("b stream bypass wrong");

    AST_DEPTH_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // R19
        rs_depth == $past(depth_ff))
        else $error("interleave depth not applied");

    AST_DEPTH_TAKE: assert property (@(posedge sys_clk) disable iff (sys_rst) // R20
        (wr && hit_depth && depth_ok) |=> depth_ff == $past(wr_depth))
        else $error("valid depth not taken");

    AST_RATE_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
        (wr && hit_ldpc && !rate_ok) |=> ldpc_rate_ff == $past(ldpc_rate_ff))
        else $error("bad rate code not rejected");

    AST_DRND_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
        (wr && hit_ldpc && !drnd_ok) |=> ldpc_drnd_ff == $past(ldpc_drnd_ff))
        else $error("bad derandomizer code not rejected");

    AST_ROUTE_ANY: assert property (@(posedge sys_clk) disable iff (sys_rst) // R22
        !path_bypass |-> ldpc_en || vit_i_en || rs_en)
        else $error("no bypass and no decoder");

    AST_PREADY_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pready |=> !pready)
        else $error("pready held past one cycle");

    COV_LDPC: cover property (@(posedge sys_clk) ldpc_en && ldpc_k == fec_select_pkg::K_SMALL);
    COV_JOINT: cover property (@(posedge sys_clk) vit_joint && rs_en);
    COV_ASYM: cover property (@(posedge sys_clk) rs_b_bypass);
    COV_DEPTH: cover property (@(posedge sys_clk) wr && hit_depth && !depth_ok);
    COV_SEPARATE: cover property (@(posedge sys_clk) vit_i_en && vit_q_en && rs_b_bypass);

endmodule

//--- inc/fec_select_pkg.sv
package fec_select_pkg;

    // bus map (byte addresses)
    localparam logic [7:0]  ADDR_MODE      = 8'h00;
    localparam logic [7:0]  ADDR_LDPC      = 8'h04;
    localparam logic [7:0]  ADDR_LEGACY    = 8'h08;
    localparam logic [7:0]  ADDR_DEPTH     = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS    = 8'h10;

    // waveform mode codes
    localparam logic [3:0]  MODE_PCMFM     = 4'h0;
    localparam logic [3:0]  MODE_SOQPSK    = 4'h1;
    localparam logic [3:0]  MODE_SOQ_LDPC  = 4'h2;
    localparam logic [3:0]  MODE_STC_LDPC  = 4'h3;
    localparam logic [3:0]  MODE_BPSK      = 4'h4;
    localparam logic [3:0]  MODE_QPSK      = 4'h5;
    localparam logic [3:0]  MODE_OQPSK     = 4'h6;
    localparam logic [3:0]  MODE_UQPSK     = 4'h7;
    localparam logic [3:0]  MODE_ASYMMETRIC_QUADRATURE_PSK     = 4'h8;
    localparam logic [3:0]  MODE_ASYMMETRIC_UNBALANCED_QUADRATURE_PSK    = 4'h9;

    // ldpc register fields
    localparam int          LDPC_RATE_LSB  = 0;   // 2 bits: 0=1/2 1=2/3 2=4/5
    localparam int          LDPC_SIZE_BIT  = 2;   // 0=k4096 1=k1024
    localparam int          LDPC_DRND_LSB  = 4;   // 2 bits: 0=none 1=range 2=space
    localparam logic [1:0]  RATE_1_2       = 2'h0;
    localparam logic [1:0]  RATE_2_3       = 2'h1;
    localparam logic [1:0]  RATE_4_5       = 2'h2;
    localparam logic [1:0]  DRND_NONE      = 2'h0;
    localparam logic [1:0]  DRND_RANGE     = 2'h1;
    localparam logic [1:0]  DRND_SPACE     = 2'h2;
    localparam logic [12:0] K_LARGE        = 13'h1000;
    localparam logic [12:0] K_SMALL        = 13'h0400;

    // legacy register fields
    localparam int          VIT_EN_BIT     = 0;
    localparam int          RS_EN_BIT      = 1;
    localparam int          CSYM_BIT       = 2;

    // fixed legacy code figures
    localparam logic [3:0]  CONV_K         = 4'h7;
    localparam logic [7:0]  RS_N           = 8'hFF;
    localparam logic [7:0]  RS_K           = 8'hDF;
    localparam logic [3:0]  DEPTH_MIN      = 4'h1;
    localparam logic [3:0]  DEPTH_MAX      = 4'h8;

    // status fields
    localparam int          ST_LDPC_BIT    = 0;
    localparam int          ST_VIT_BIT     = 1;
    localparam int          ST_RS_BIT      = 2;
    localparam int          ST_JOINT_BIT   = 3;
    localparam int          ST_DUAL_BIT    = 4;
    localparam int          ST_BPASS_BIT   = 5;
    localparam int          ST_ERR_BIT     = 6;

endpackage

//--- verif/fec_far_end_model.sv
`timescale 1ns/10ps
module fec_far_end_model (
    // decoder routing seen from the far end
    input  wire logic        ldpc_en,
    input  wire logic [12:0] ldpc_k,
    input  wire logic [1:0]  ldpc_rate,
    input  wire logic [1:0]  derand_sel,
    input  wire logic        vit_i_en,
    input  wire logic        vit_q_en,
    input  wire logic        vit_joint,
    input  wire logic        rs_en,
    input  wire logic        path_bypass,
    // transmitter settings and route check
    output logic [12:0]      tx_k,
    output logic [1:0]       tx_rate,
    output logic [1:0]       tx_rand,
    output logic             afc_off,
    output logic             route_ok
);
    // the encoder must follow the receiver, or every block fails to decode
    assign tx_k     = ldpc_k;
    assign tx_rate  = ldpc_rate;
    assign tx_rand  = derand_sel;
    assign afc_off  = 1'h1;
    // raw data is only safe when no core claims the stream
    assign route_ok = ((ldpc_en | vit_i_en | vit_q_en | vit_joint | rs_en) == !path_bypass)
                      && !(ldpc_en && (vit_i_en | vit_joint | rs_en));
endmodule

//--- verif/telemetry_fec_decode_select_test.sv
`timescale 1ns/10ps
module telemetry_fec_decode_select_test;
    typedef struct {
        logic        opt;
        logic [3:0]  mode;
        logic [7:0]  ldpc;
        logic [2:0]  leg;
        logic [8:0]  flags;
        logic [12:0] k;
        logic [1:0]  rate;
        logic [1:0]  drnd;
    } row_s;

    logic        sys_clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        opt = 1'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic        ldpc_en, ldpc_menu_visible, vit_i_en, vit_q_en, vit_joint, rs_en;
    logic        rs_b_bypass, legacy_menu_visible, path_bypass, afc_off, route_ok;
    logic [12:0] ldpc_k, tx_k;
    logic [1:0]  ldpc_rate, derand_sel, tx_rate, tx_rand;
    logic [3:0]  rs_depth;
    logic [8:0]  flags_seen;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;
    row_s        rows [16];
    logic [31:0] bad [3] = '{32'h9, 32'h0, 32'h11};

    assign flags_seen = {ldpc_en, ldpc_menu_visible, legacy_menu_visible, vit_i_en,
                         vit_q_en, vit_joint, rs_en, rs_b_bypass, path_bypass};

    telemetry_fec_decode_select telemetry_fec_decode_select_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .convolutional_decoding_option(opt),
        .ldpc_en(ldpc_en), .ldpc_k(ldpc_k), .ldpc_rate(ldpc_rate),
        .derand_sel(derand_sel), .ldpc_menu_visible(ldpc_menu_visible),
        .vit_i_en(vit_i_en), .vit_q_en(vit_q_en), .vit_joint(vit_joint),
        .rs_en(rs_en), .rs_b_bypass(rs_b_bypass), .rs_depth(rs_depth),
        .legacy_menu_visible(legacy_menu_visible), .path_bypass(path_bypass));

    fec_far_end_model fec_far_end_model_inst (
        .ldpc_en(ldpc_en), .ldpc_k(ldpc_k), .ldpc_rate(ldpc_rate),
        .derand_sel(derand_sel), .vit_i_en(vit_i_en), .vit_q_en(vit_q_en),
        .vit_joint(vit_joint), .rs_en(rs_en), .path_bypass(path_bypass),
        .tx_k(tx_k), .tx_rate(tx_rate), .tx_rand(tx_rand), .afc_off(afc_off),
        .route_ok(route_ok));

    always #20 sys_clk = ~sys_clk;

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    // wait on pready, then require a single access cycle: any wait state fails the access-cycles check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        check(32'(n), 32'h1, "access cycles");
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        rows = '{
            '{1'h1, 4'h0, 8'h00, 3'h3, 9'h001, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h1, 8'h12, 3'h3, 9'h001, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h2, 8'h00, 3'h3, 9'h180, 13'h1000, 2'h0, 2'h0},
            '{1'h1, 4'h2, 8'h15, 3'h0, 9'h180, 13'h0400, 2'h1, 2'h1},
            '{1'h1, 4'h3, 8'h26, 3'h0, 9'h180, 13'h0400, 2'h2, 2'h2},
            '{1'h1, 4'h3, 8'h21, 3'h0, 9'h180, 13'h1000, 2'h1, 2'h2},
            '{1'h1, 4'h2, 8'h02, 3'h0, 9'h180, 13'h1000, 2'h2, 2'h0},
            '{1'h1, 4'h3, 8'h04, 3'h0, 9'h180, 13'h0400, 2'h0, 2'h0},
            '{1'h1, 4'h4, 8'h00, 3'h1, 9'h060, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h5, 8'h00, 3'h1, 9'h070, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h6, 8'h00, 3'h5, 9'h068, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h7, 8'h00, 3'h2, 9'h044, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h8, 8'h00, 3'h3, 9'h076, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h9, 8'h00, 3'h7, 9'h06E, 13'h0000, 2'h0, 2'h0},
            '{1'h0, 4'h5, 8'h00, 3'h3, 9'h001, 13'h0000, 2'h0, 2'h0},
            '{1'h1, 4'h4, 8'h00, 3'h0, 9'h041, 13'h0000, 2'h0, 2'h0}};
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'h0;
        @(posedge sys_clk);
        check(32'(ldpc_k), 32'h1000, "reset block size");
        check(32'(rs_depth), 32'h1, "reset depth");
        check(32'({ldpc_en, path_bypass}), 32'h1, "reset routing");
        $display("test reset done");
        foreach (rows[i]) begin
            opt <= rows[i].opt;
            apb(1'h1, fec_select_pkg::ADDR_MODE, 32'(rows[i].mode));
            apb(1'h1, fec_select_pkg::ADDR_LDPC, 32'(rows[i].ldpc));
            apb(1'h1, fec_select_pkg::ADDR_LEGACY, 32'(rows[i].leg));
            repeat (3) @(posedge sys_clk);
            check(32'(flags_seen), 32'(rows[i].flags), "routing");
            check(32'(derand_sel), 32'(rows[i].drnd), "derandomizer");
            if (rows[i].flags[8]) begin
                check(32'({ldpc_k, ldpc_rate}), 32'({rows[i].k, rows[i].rate}), "code pair");
                check(32'({tx_k, tx_rate}), 32'({rows[i].k, rows[i].rate}), "encoder pair");
            end
            check(32'({route_ok, afc_off, tx_rand}), 32'({2'h3, rows[i].drnd}), "far end");
        end
        $display("test table done");
        for (int d = 1; d <= 8; d++) begin
            apb(1'h1, fec_select_pkg::ADDR_DEPTH, 32'(d));
            repeat (2) @(posedge sys_clk);
            check(32'(rs_depth), 32'(d), "depth accepted");
        end
        foreach (bad[j]) begin
            apb(1'h1, fec_select_pkg::ADDR_DEPTH, bad[j]);
            apb(1'h0, fec_select_pkg::ADDR_STATUS, 32'h0);
            check(32'({rs_depth, rd[fec_select_pkg::ST_ERR_BIT]}), 32'h11, "depth rejected");
        end
        apb(1'h1, fec_select_pkg::ADDR_DEPTH, 32'h3);
        apb(1'h0, fec_select_pkg::ADDR_STATUS, 32'h0);
        check(32'({rs_depth, rd[fec_select_pkg::ST_ERR_BIT]}), 32'h6, "depth recovered");
        $display("test depth done");
        apb(1'h1, fec_select_pkg::ADDR_MODE, 32'h2);
        apb(1'h1, fec_select_pkg::ADDR_LDPC, 32'h11);
        apb(1'h1, fec_select_pkg::ADDR_LDPC, 32'h33);
        repeat (2) @(posedge sys_clk);
        check(32'({ldpc_rate, derand_sel}), 32'h5, "bad codes kept");
        apb(1'h1, 8'h14, 32'h5);
        check(32'(err), 32'h1, "unmapped write");
        apb(1'h0, 8'h14, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        apb(1'h0, fec_select_pkg::ADDR_MODE, 32'h0);
        check(rd, 32'h2, "mode readback");
        $display("test awkward done");
        conclude();
    end
endmodule
